/* rhm_pkg.sv */
// shared constants and types for the reset and hardware mode control block
package rhm_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] OFF_TX_INSERT = 8'h00;
    localparam logic [7:0] OFF_TX_EXTRA = 8'h04;
    localparam logic [7:0] OFF_COMMON = 8'h08;
    localparam logic [7:0] OFF_TX_CTL = 8'h0C;
    localparam logic [7:0] OFF_RX_CTL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_CRC_CNT = 8'h18;
    localparam logic [7:0] OFF_FRAME_CNT = 8'h1C;
    // mapped bit positions inside the control registers
    localparam int BIT_TX_REMOTE_ALARM = 5;
    localparam int BIT_TX_DIST_MF_ALARM = 2;
    localparam int BIT_TX_HDB3 = 5;
    localparam int BIT_RX_HDB3 = 4;
    localparam int BIT_TX_CRC4 = 3;
    localparam int BIT_RX_CRC4 = 2;
    localparam int BIT_CAS_MF = 5;
    // status register field
    localparam int BIT_STAT_LOS = 0;
    localparam int BIT_STAT_HW_MODE = 1;
    // mode input indices
    localparam int MODE_REMOTE_ALARM = 0;
    localparam int MODE_DIST_MF_ALARM = 1;
    localparam int MODE_LINE_CODE = 2;
    localparam int MODE_CRC4 = 3;
    localparam int MODE_CAS = 4;
    localparam int MODE_PINS = 5;
    // reset and saturation values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_SAT = 8'hFF;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // framer control set seen by the datapaths
    typedef struct packed {
        logic [7:0] tx_insert_control_reg;
        logic [7:0] tx_extra_control_reg;
        logic [7:0] common_control_reg;
        logic [7:0] tx_control_reg;
        logic [7:0] rx_control_reg;
    } rhm_ctl_t;
endpackage

/* rhm_reset_hwmode.sv */
// reset handling, hardware mode pin mapping and axi4-lite control registers
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - chip reset clears controls, keeps error counters
// - resync starts at reset, holds while low
// - port select low: bus off, pins control
// - mode pin 0 drives transmit remote alarm
// - mode pin 1 drives distant multiframe alarm
// - mode pin 2 selects AMI or HDB3
// - mode pin 3 enables CRC4 multiframing both ways
// - mode pin 4 low enables CAS multiframing
// - loss of sync high during resync
// - no CRC4/frame counting during resync
////////////////////////////////////////////////////////////////////////////////
module rhm_reset_hwmode (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic chip_rst_n,
    input wire logic port_select,
    input wire logic [4:0] mode_in,
    input wire logic rx_sync_found,
    input wire logic crc_err_evt,
    input wire logic frame_err_evt,
    output rhm_pkg::rhm_ctl_t ctl,
    output logic rx_loss_of_sync,
    output logic resync_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    rhm_pkg::rhm_ctl_t ctl_q; // control registers
    rhm_pkg::rhm_ctl_t ctl_d;
    logic [7:0] crc_cnt_q; // crc4 error counter
    logic [7:0] crc_cnt_d;
    logic [7:0] frm_cnt_q; // frame error counter
    logic [7:0] frm_cnt_d;
    logic los_q; // resync in progress
    logic aw_held_q; // write address taken
    logic w_held_q; // write data taken
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q; // lane 0 strobe, taken together with the data
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire hw_mode = ~port_select; // bus disabled, pins steer the mapped bits
    wire chip_rst = ~chip_rst_n;
    wire wr_go = aw_held_q & w_held_q & ~bvalid_q; // both halves present
    // the strobe is latched: a master may move it once its data has been taken
    wire wr_en = wr_go & ~hw_mode & ~chip_rst & wstrb0_q;
    wire sel_w_tx_insert_control_reg = wr_en && (awaddr_q == rhm_pkg::OFF_TX_INSERT);
    wire sel_w_txr = wr_en && (awaddr_q == rhm_pkg::OFF_TX_EXTRA);
    wire sel_w_ccr = wr_en && (awaddr_q == rhm_pkg::OFF_COMMON);
    wire sel_w_tcr = wr_en && (awaddr_q == rhm_pkg::OFF_TX_CTL);
    wire sel_w_rcr = wr_en && (awaddr_q == rhm_pkg::OFF_RX_CTL);
    wire sel_w_crc = wr_en && (awaddr_q == rhm_pkg::OFF_CRC_CNT);
    wire sel_w_frm = wr_en && (awaddr_q == rhm_pkg::OFF_FRAME_CNT);
    wire wr_mapped = (awaddr_q[7:5] == 3'h0) && (awaddr_q[1:0] == 2'h0);
    wire [1:0] wr_resp = (hw_mode || !wr_mapped) ? rhm_pkg::RESP_SLVERR : rhm_pkg::RESP_OKAY;
    wire [7:0] wbyte = wdata_q[7:0];
    // counting is frozen while resync runs
    wire crc_inc = crc_err_evt & ~los_q & (crc_cnt_q != rhm_pkg::CNT_SAT);
    wire frm_inc = frame_err_evt & ~los_q & (frm_cnt_q != rhm_pkg::CNT_SAT);

    ////////////////////////////////////////////////////////////////////////////
    // control register next value
    always_comb begin
        ctl_d = ctl_q;
        if (sel_w_tx_insert_control_reg) begin
            ctl_d.tx_insert_control_reg = wbyte;
        end
        if (sel_w_txr) begin
            ctl_d.tx_extra_control_reg = wbyte;
        end
        if (sel_w_ccr) begin
            ctl_d.common_control_reg = wbyte;
        end
        if (sel_w_tcr) begin
            ctl_d.tx_control_reg = wbyte;
        end
        if (sel_w_rcr) begin
            ctl_d.rx_control_reg = wbyte;
        end
        // hardware mode: everything clear except the pin driven bits
        if (hw_mode) begin
            ctl_d = '0;
            ctl_d.tx_insert_control_reg[rhm_pkg::BIT_TX_REMOTE_ALARM] =
                mode_in[rhm_pkg::MODE_REMOTE_ALARM];
            ctl_d.tx_extra_control_reg[rhm_pkg::BIT_TX_DIST_MF_ALARM] =
                mode_in[rhm_pkg::MODE_DIST_MF_ALARM];
            ctl_d.common_control_reg[rhm_pkg::BIT_TX_HDB3] = mode_in[rhm_pkg::MODE_LINE_CODE];
            ctl_d.common_control_reg[rhm_pkg::BIT_RX_HDB3] = mode_in[rhm_pkg::MODE_LINE_CODE];
            ctl_d.common_control_reg[rhm_pkg::BIT_TX_CRC4] = mode_in[rhm_pkg::MODE_CRC4];
            ctl_d.common_control_reg[rhm_pkg::BIT_RX_CRC4] = mode_in[rhm_pkg::MODE_CRC4];
            // register bit set means cas multiframing on, so the pin is inverted
            ctl_d.tx_control_reg[rhm_pkg::BIT_CAS_MF] = ~mode_in[rhm_pkg::MODE_CAS];
            ctl_d.rx_control_reg[rhm_pkg::BIT_CAS_MF] = ~mode_in[rhm_pkg::MODE_CAS];
        end
        // chip reset clears all controls, and overrides the pins
        if (chip_rst) begin
            ctl_d = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters: a software preset beats a same cycle error event
    assign crc_cnt_d = sel_w_crc ? wbyte : (crc_inc ? crc_cnt_q + 8'h01 : crc_cnt_q);
    assign frm_cnt_d = sel_w_frm ? wbyte : (frm_inc ? frm_cnt_q + 8'h01 : frm_cnt_q);

    // control and counters; chip reset leaves counters alone
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= '0;
            crc_cnt_q <= rhm_pkg::CNT_RESET;
            frm_cnt_q <= rhm_pkg::CNT_RESET;
        end else begin
            ctl_q <= ctl_d;
            crc_cnt_q <= crc_cnt_d;
            frm_cnt_q <= frm_cnt_d;
        end
    end

    // resync: forced while chip reset is low, ends on sync found
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            los_q <= 1'b1;
        end else if (chip_rst) begin
            los_q <= 1'b1;
        end else if (rx_sync_found) begin
            los_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel; address and data taken in either order
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= rhm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_resp;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read decode; in hardware mode the bus answers slverr
    wire rd_mapped = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
    wire [7:0] stat_byte = {6'h00, hw_mode, los_q};
    wire [7:0] rd_byte =
        (s_axi_araddr == rhm_pkg::OFF_TX_INSERT) ? ctl_q.tx_insert_control_reg :
        (s_axi_araddr == rhm_pkg::OFF_TX_EXTRA) ? ctl_q.tx_extra_control_reg :
        (s_axi_araddr == rhm_pkg::OFF_COMMON) ? ctl_q.common_control_reg :
        (s_axi_araddr == rhm_pkg::OFF_TX_CTL) ? ctl_q.tx_control_reg :
        (s_axi_araddr == rhm_pkg::OFF_RX_CTL) ? ctl_q.rx_control_reg :
        (s_axi_araddr == rhm_pkg::OFF_STATUS) ? stat_byte :
        (s_axi_araddr == rhm_pkg::OFF_CRC_CNT) ? crc_cnt_q :
        (s_axi_araddr == rhm_pkg::OFF_FRAME_CNT) ? frm_cnt_q : 8'h00;
    wire rd_ok = rd_mapped & ~hw_mode;

    // axi read channel, one read at a time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= rhm_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_ok ? rhm_pkg::RESP_OKAY : rhm_pkg::RESP_SLVERR;
            rdata_q <= rd_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign ctl = ctl_q;
    assign rx_loss_of_sync = los_q;
    assign resync_req = los_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_rst_clears_ctl: assert property (@(posedge clk_sys) disable iff (!resetn)
        !chip_rst_n |=> (ctl_q == '0)) else $error("chip reset did not clear controls");
    a_rst_keeps_cnt: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!chip_rst_n && !crc_err_evt && !sel_w_crc) |=> $stable(crc_cnt_q))
        else $error("chip reset disturbed crc counter");
    a_rst_forces_los: assert property (@(posedge clk_sys) disable iff (!resetn)
        !chip_rst_n |=> rx_loss_of_sync) else $error("loss of sync low during chip reset");
    a_hw_bus_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_go && hw_mode) |=> (s_axi_bvalid && s_axi_bresp == rhm_pkg::RESP_SLVERR))
        else $error("bus write accepted in hardware mode");
    a_hw_remote_alarm: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hw_mode && chip_rst_n) |=> (ctl_q.tx_insert_control_reg ==
        {2'h0, $past(mode_in[rhm_pkg::MODE_REMOTE_ALARM]), 5'h00}))
        else $error("remote alarm bit not following pin");
    a_hw_dist_alarm: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hw_mode && chip_rst_n) |=> (ctl_q.tx_extra_control_reg ==
        {5'h00, $past(mode_in[rhm_pkg::MODE_DIST_MF_ALARM]), 2'h0}))
        else $error("distant alarm bit not following pin");
    a_hw_common_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hw_mode && chip_rst_n) |=> (ctl_q.common_control_reg ==
        {2'h0, {2{$past(mode_in[rhm_pkg::MODE_LINE_CODE])}}, {2{$past(mode_in[rhm_pkg::MODE_CRC4])}}, 2'h0}))
        else $error("line code or crc4 bits wrong in hardware mode");
    a_hw_cas_invert: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hw_mode && chip_rst_n) |=> (ctl_q.tx_control_reg[rhm_pkg::BIT_CAS_MF] !=
        $past(mode_in[rhm_pkg::MODE_CAS])) && (ctl_q.rx_control_reg == ctl_q.tx_control_reg))
        else $error("cas bits not inverted pin");
    a_los_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        (chip_rst_n && rx_sync_found) |=> !rx_loss_of_sync) else $error("loss of sync stuck high");
    a_no_count_resync: assert property (@(posedge clk_sys) disable iff (!resetn)
        (los_q && !sel_w_crc && !sel_w_frm) |=> ($stable(crc_cnt_q) && $stable(frm_cnt_q)))
        else $error("counter moved during resync");
    c_hw_mode_entry: cover property (@(posedge clk_sys) disable iff (!resetn)
        !chip_rst_n ##1 hw_mode ##[1:20] chip_rst_n);
    c_resync_done: cover property (@(posedge clk_sys) disable iff (!resetn)
        rx_loss_of_sync ##1 !rx_loss_of_sync);
    c_crc_saturate: cover property (@(posedge clk_sys) disable iff (!resetn)
        crc_cnt_q == rhm_pkg::CNT_SAT);
endmodule

/* rhm_reset_hwmode_bench.sv */
// self-checking bench for reset handling and hardware mode control
`timescale 1ns/100ps
module rhm_reset_hwmode_bench;
    logic clk_sys = 1'b0, resetn = 1'b0; // clock and power-up reset
    logic req_hw = 1'b0, rst_req = 1'b0; // strap requests
    logic [4:0] pins_req = 5'h00; // wanted mode pin levels
    logic rx_sync_found = 1'b0, crc_err_evt = 1'b0, frame_err_evt = 1'b0;
    wire logic chip_rst_n, port_select; // from strap model
    wire logic [4:0] mode_in;
    rhm_pkg::rhm_ctl_t ctl;
    logic rx_loss_of_sync, resync_req, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    int bad_count = 0, total_checks = 0;
    logic [3:0] wr_strb = 4'hF; // lane strobes the next write offers
    always #5 clk_sys = ~clk_sys;
    rhm_strap_model rhm_strap_model_inst (.clk_sys, .req_hw, .rst_req, .pins_req, .port_select, .mode_in, .chip_rst_n);
    rhm_reset_hwmode rhm_reset_hwmode_inst (.clk_sys, .resetn, .chip_rst_n, .port_select, .mode_in, .rx_sync_found,
        .crc_err_evt, .frame_err_evt, .ctl, .rx_loss_of_sync, .resync_req, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    ////////////////////////////////////////////////////////////////////////
    // closing report, the single exit of the run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // a used-up wait counts as a mismatch and ends the run
    task automatic hang(input logic tout);
        if (tout) begin
            bad_count++;
            $display("[ERR] bus wait timed out");
            final_report();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // bus master: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= wr_strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        hang(!s_axi_bvalid);
        chk("bresp", {38'h0, er}, {38'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        // let an edge pass so a following write never re-raises bready in this step
        cyc(1);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        hang(!s_axi_rvalid);
        chk("rresp", {38'h0, er}, {38'h0, s_axi_rresp});
        chk("rdata", {32'h0, ed}, {8'h0, s_axi_rdata});
        s_axi_rready <= 1'b0;
        // one idle edge before the next read raises rready again
        cyc(1);
    endtask
    // k error pulses of one cycle, spaced by an idle cycle
    task automatic evt(input logic c, input logic f, input int k);
        repeat (k) begin
            crc_err_evt <= c;
            frame_err_evt <= f;
            cyc(1);
            crc_err_evt <= 1'b0;
            frame_err_evt <= 1'b0;
            cyc(1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenario: state straight after power-up reset
    task automatic t_reset();
        chk("ctl", 40'h0, ctl);
        chk("los", 40'h1, {39'h0, rx_loss_of_sync});
        chk("resync", 40'h1, {39'h0, resync_req});
        axi_rd(rhm_pkg::OFF_STATUS, 8'h01, rhm_pkg::RESP_OKAY);
    endtask
    // scenario: counters frozen in resync, count and saturate once locked
    task automatic t_count();
        evt(1'b1, 1'b1, 2);
        axi_rd(rhm_pkg::OFF_CRC_CNT, 8'h00, rhm_pkg::RESP_OKAY);
        axi_rd(rhm_pkg::OFF_FRAME_CNT, 8'h00, rhm_pkg::RESP_OKAY);
        rx_sync_found <= 1'b1;
        cyc(1);
        rx_sync_found <= 1'b0;
        cyc(2);
        chk("los", 40'h0, {39'h0, rx_loss_of_sync});
        axi_wr(rhm_pkg::OFF_CRC_CNT, 8'hFE, rhm_pkg::RESP_OKAY);
        evt(1'b1, 1'b0, 2);
        evt(1'b0, 1'b1, 1);
        axi_rd(rhm_pkg::OFF_CRC_CNT, 8'hFF, rhm_pkg::RESP_OKAY);
        axi_rd(rhm_pkg::OFF_FRAME_CNT, 8'h01, rhm_pkg::RESP_OKAY);
    endtask
    // scenario: chip reset clears controls, keeps counts, restarts resync
    task automatic t_chip_rst();
        axi_wr(rhm_pkg::OFF_TX_INSERT, 8'h5A, rhm_pkg::RESP_OKAY);
        axi_wr(rhm_pkg::OFF_COMMON, 8'h3C, rhm_pkg::RESP_OKAY);
        chk("ctl", 40'h5A_00_3C_00_00, ctl);
        rst_req <= 1'b1;
        cyc(4);
        chk("ctl", 40'h0, ctl);
        chk("los", 40'h1, {39'h0, rx_loss_of_sync});
        rst_req <= 1'b0;
        cyc(3);
        chk("los", 40'h1, {39'h0, rx_loss_of_sync});
        axi_rd(rhm_pkg::OFF_CRC_CNT, 8'hFF, rhm_pkg::RESP_OKAY);
        axi_rd(rhm_pkg::OFF_FRAME_CNT, 8'h01, rhm_pkg::RESP_OKAY);
        axi_wr(rhm_pkg::OFF_TX_INSERT, 8'hA5, rhm_pkg::RESP_OKAY);
        axi_rd(rhm_pkg::OFF_TX_INSERT, 8'hA5, rhm_pkg::RESP_OKAY);
        // lane 0 strobe low: answered okay, nothing stored
        wr_strb = 4'hE;
        axi_wr(rhm_pkg::OFF_TX_INSERT, 8'h11, rhm_pkg::RESP_OKAY);
        wr_strb = 4'hF;
        axi_rd(rhm_pkg::OFF_TX_INSERT, 8'hA5, rhm_pkg::RESP_OKAY);
        axi_wr(8'h20, 8'h11, rhm_pkg::RESP_SLVERR);
        axi_rd(8'h20, 8'h00, rhm_pkg::RESP_SLVERR);
    endtask
    // scenario: strapped mode, none, each pin alone, all, then back to bus
    task automatic t_hw_mode();
        logic [4:0] p;
        logic [39:0] e;
        req_hw <= 1'b1;
        cyc(8);
        for (int i = 0; i < 7; i++) begin
            p = (i == 0) ? 5'h00 : (i == 6) ? 5'h1F : 5'h01 << (i - 1);
            pins_req <= p;
            cyc(3);
            e = {2'h0, p[0], 10'h0, p[1], 4'h0, p[2], p[2], p[3], p[3], 4'h0, ~p[4], 7'h0, ~p[4], 5'h0};
            chk("hw ctl", e, ctl);
        end
        axi_rd(rhm_pkg::OFF_COMMON, 8'h00, rhm_pkg::RESP_SLVERR);
        axi_wr(rhm_pkg::OFF_COMMON, 8'h3C, rhm_pkg::RESP_SLVERR);
        req_hw <= 1'b0;
        cyc(8);
        chk("ctl", 40'h0, ctl);
        axi_rd(rhm_pkg::OFF_STATUS, 8'h01, rhm_pkg::RESP_OKAY);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cyc(10);
        resetn <= 1'b1;
        cyc(1);
        t_reset();
        t_count();
        t_chip_rst();
        t_hw_mode();
        final_report();
    end
endmodule

/* rhm_strap_model.sv */
// discrete strap logic model driving port select, mode pins and chip reset
`timescale 1ns/100ps
module rhm_strap_model (
    input wire logic clk_sys,
    input wire logic req_hw,
    input wire logic rst_req,
    input wire logic [4:0] pins_req,
    output logic port_select = 1'b1,
    output logic [4:0] mode_in = 5'h00,
    output logic chip_rst_n = 1'b1
);
    logic [1:0] sw_q = 2'h0; // cycles left in a mode switch
    ////////////////////////////////////////////////////////////////////////
    // port select changes only ever happen inside a held chip reset
    always @(posedge clk_sys) begin
        mode_in <= pins_req;
        if (sw_q != 2'h0) begin
            sw_q <= sw_q - 2'h1;
            // flip select mid-way so reset brackets it on both sides
            if (sw_q == 2'h2) port_select <= !req_hw;
        end else if (port_select == req_hw) begin
            sw_q <= 2'h3;
        end
        chip_rst_n <= !(rst_req || sw_q != 2'h0 || port_select == req_hw);
    end
endmodule
